// ---- test/eirq_host.sv ----
// Host processor model acting as APB master towards the register bank.
`timescale 1ns/10ps
module eirq_host (
   input  wire logic        core_clk,        // Bus clock.
   input  wire logic        pready,          // Slave ready.
   output logic             psel    = 1'b0,  // Select.
   output logic             penable = 1'b0,  // Access phase.
   output logic             pwrite  = 1'b0,  // Direction.
   output logic [11:0]      paddr   = 12'h0, // Byte address.
   output logic [31:0]      pwdata  = 32'h0, // Write data.
   output logic [3:0]       pstrb   = 4'h0   // Byte strobes.
);
   // Holds the request until pready is seen high at a rising edge.
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= 4'hF;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released address and data lines show a changed value, never the stale one.
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask : xfer
endmodule : eirq_host

// ---- test/eirq_regs_properties.sv ----
// Concurrent checks on the edge interrupt, DMA and power register bank.
`timescale 1ns/10ps
module eirq_regs_chk #(
   parameter int MFRAME_CYCLES = eirq_pkg::MFRAME_CYC,
   parameter int WAKE_CYCLES   = eirq_pkg::WAKE_UNIT_CYC
) (
   input wire logic                core_clk,     // Clock.
   input wire logic                sys_rst,      // Reset.
   input wire logic                psel,         // APB select.
   input wire logic                penable,      // APB enable.
   input wire logic                pwrite,       // APB direction.
   input wire logic [11:0]         paddr,        // APB address.
   input wire logic [31:0]         pwdata,       // APB write data.
   input wire logic [3:0]          pstrb,        // APB strobes.
   input wire logic                pready,       // APB ready.
   input wire logic [31:0]         prdata,       // APB read data.
   input wire logic                pslverr,      // APB error.
   input wire logic                irqEvent,     // Event pulse.
   input wire logic                wakeEventPin, // Wake pin.
   input wire logic                hostIrq,      // Interrupt out.
   input wire logic                intr,         // Status interrupt.
   input wire logic [15:0]         dmaStartAddr, // DMA pointer.
   input wire logic                suspendReq,   // Suspend request.
   input wire eirq_pkg::eirq_pwr_t powerCtl      // Power enables.
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire        wrDone = psel && penable && pready && pwrite;
   logic [15:0] pulseLen_q, dma_q, wake_q, since_q;
   logic [7:0]  gap_q;
   logic [31:0] pwr_q, hiCnt_q, awake_q;
   logic        level_q, bus16_q, prevHi_q, seenUp_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pulseLen_q <= 16'h000F;
         gap_q      <= 8'h00;
         level_q    <= 1'b0;
         bus16_q    <= 1'b0;
         wake_q     <= 16'h03E8;
      end else if (wrDone) begin
         if (paddr == 12'h340) begin
            gap_q      <= pwdata[31:24];
            pulseLen_q <= pwdata[15:0];
         end
         if (paddr == 12'h358) {bus16_q, level_q} <= pwdata[1:0];
         if (paddr == 12'h354) begin
            wake_q <= bus16_q ? 16'h1400 : pwdata[31:16];
            pwr_q  <= pwdata;
         end
         if (paddr == 12'h344) dma_q <= pwdata[15:0];
      end
   end
   // Counters measure pulse length, pulse spacing and time awake.
   always_ff @(posedge core_clk) begin
      prevHi_q <= hostIrq;
      hiCnt_q  <= hostIrq ? hiCnt_q + 1 : 0;
      awake_q  <= suspendReq ? 0 : awake_q + 1;
      seenUp_q <= !sys_rst && (seenUp_q || suspendReq);
      // Cycles since the last rising edge of the interrupt, saturating.
      if (sys_rst) since_q <= 16'hFFFF;
      else if (hostIrq && !prevHi_q) since_q <= 16'h0001;
      else if (since_q != 16'hFFFF) since_q <= since_q + 16'h0001;
   end
   chk_gap_spacing: assert property ($rose(hostIrq) && !level_q
      |-> since_q >= gap_q * MFRAME_CYCLES)
      else $error("edge pulses too close");
   chk_level_follow: assert property (level_q && irqEvent |=> hostIrq)
      else $error("level interrupt not raised");
   chk_zero_gap: assert property (irqEvent && !hostIrq && !level_q &&
      gap_q == 0 |-> ##2 hostIrq) else $error("edge pulse late");
   chk_pulse_len: assert property ($fell(hostIrq) && !level_q |->
      hiCnt_q == (pulseLen_q == 0 ? 16 : pulseLen_q))
      else $error("pulse length");
   chk_dma_ptr: assert property (wrDone && paddr == 12'h344 |=>
      ##[0:1] dmaStartAddr == dma_q) else $error("DMA pointer not loaded");
   chk_dma_wo: assert property (psel && pready && !pwrite &&
      paddr == 12'h344 |-> prdata == 32'h0)
      else $error("DMA pointer readable");
   chk_power_map: assert property (wrDone && paddr == 12'h354
      |=> ##[0:1] powerCtl == {pwr_q[11], pwr_q[12], pwr_q[10], pwr_q[5],
      pwr_q[4], pwr_q[1], pwr_q[2], pwr_q[3], pwr_q[0]})
      else $error("power enables");
   chk_wake_hold: assert property ($rose(suspendReq) && seenUp_q |->
      awake_q + 1 >= wake_q * WAKE_CYCLES &&
      awake_q <= wake_q * WAKE_CYCLES + 1)
      else $error("wake interval wrong");
   cover property ($rose(hostIrq) && !level_q);
   cover property ($fell(suspendReq));
   cover property (pslverr && pready);
endmodule : eirq_regs_chk
bind eirq_regs eirq_regs_chk #(.MFRAME_CYCLES(MFRAME_CYCLES),
   .WAKE_CYCLES(WAKE_CYCLES)) eirq_regs_chk_inst (.core_clk(core_clk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .irqEvent(irqEvent),
   .wakeEventPin(wakeEventPin), .hostIrq(hostIrq), .intr(intr),
   .dmaStartAddr(dmaStartAddr), .suspendReq(suspendReq), .powerCtl(powerCtl));

// ---- test/test_edge_irq_dma_pwr_regs.sv ----
// Self-checking bench for the edge interrupt, DMA and power register bank.
`timescale 1ns/10ps
module test_edge_irq_dma_pwr_regs;
   logic                core_clk     = 1'b0;
   logic                sys_rst      = 1'b1;
   logic                irqEvent     = 1'b0;
   logic                wakeEventPin = 1'b0;
   logic                psel, penable, pwrite, pready, pslverr;
   logic                hostIrq, intr, suspendReq;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, rnd;
   logic [3:0]          pstrb;
   logic [15:0]         dmaStartAddr;
   eirq_pkg::eirq_pwr_t powerCtl;
   logic [32:0]         expQ[$];
   int                  n_fail       = 0;
   int                  total_checks = 0;

   always #5 core_clk = ~core_clk;

   eirq_host eirq_host_inst (.core_clk(core_clk), .pready(pready),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb));
   eirq_regs #(.MFRAME_CYCLES(20), .WAKE_CYCLES(10)) eirq_regs_inst (
      .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .irqEvent(irqEvent), .wakeEventPin(wakeEventPin), .hostIrq(hostIrq),
      .intr(intr), .dmaStartAddr(dmaStartAddr), .suspendReq(suspendReq),
      .powerCtl(powerCtl));

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      eirq_host_inst.xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      expQ.push_back(e);
      eirq_host_inst.xfer(1'b0, a, 32'h0);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic fire();
      @(posedge core_clk) irqEvent <= 1'b1;
      @(posedge core_clk) irqEvent <= 1'b0;
   endtask : fire
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test

   always @(posedge core_clk) begin
      if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
         check({pslverr, prdata}, expQ.pop_front());
      end
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      finish_test();
   end

   initial begin
      void'($urandom(8545));
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      tick(2);
      check(suspendReq, 1'b1);
      check(powerCtl, 9'h1A0);
      rd(12'h340, 33'h00000000F);
      rd(12'h344, 33'h000000000);
      rd(12'h354, 33'h003E81BA0);
      rd(12'h300, 33'h100000000);
      wr(12'h360, 32'h00000003);
      wr(12'h340, 32'h00000000);
      fire();
      tick(30);
      check(intr, 1'b1);
      rd(12'h35C, 33'h000000001);
      wr(12'h35C, 32'h00000001);
      tick(2);
      check(intr, 1'b0);
      rnd = $urandom_range(40, 1);
      wr(12'h340, {16'h0000, rnd[15:0]});
      fire();
      tick(60);
      wr(12'h340, 32'h02000005);
      fire();
      tick(3);
      fire();
      tick(100);
      rnd = $urandom;
      wr(12'h344, {16'h0000, rnd[15:0]});
      tick(2);
      check(dmaStartAddr, rnd[15:0]);
      rd(12'h344, 33'h000000000);
      wr(12'h35C, 32'h00000001);
      wr(12'h358, 32'h00000001);
      fire();
      tick(2);
      check(hostIrq, 1'b1);
      wr(12'h35C, 32'h00000001);
      tick(3);
      check(hostIrq, 1'b0);
      wr(12'h358, 32'h00000000);
      wr(12'h354, 32'h00031BA0);
      @(posedge core_clk) wakeEventPin <= 1'b1;
      tick(2);
      for (int i = 0; i < 20 && suspendReq !== 1'b0; i++) tick(1);
      check(suspendReq, 1'b0);
      for (int i = 0; i < 60 && suspendReq !== 1'b1; i++) tick(1);
      check(suspendReq, 1'b1);
      tick(2);
      check(intr, 1'b1);
      rd(12'h35C, 33'h000000002);
      wakeEventPin <= 1'b0;
      wr(12'h358, 32'h00000002);
      wr(12'h354, 32'h00051BA0);
      rd(12'h354, 33'h014001BA0);
      tick(5);
      finish_test();
   end
endmodule : test_edge_irq_dma_pwr_regs

// ---- verilog/eirq_pkg.sv ----
// Constants, register map and types for the edge interrupt, DMA and power bank.
//
// Overview of operation
// - Bits 31:24 set microframe gap between pulses.
// - Gap applies to edge mode only.
// - Zero gap issues pulses immediately.
// - Bits 15:0 set pulse length in clocks.
// - Zero pulse count gives sixteen-clock pulse.
// - Default settings give a short pulse.
// - Timing register resets to 0000000Fh.
// - DMA start pointer bits 15:0 drive DMA.
// - DMA pointer is write-only, resets zero.
// - Power register holds wake count and enables.
// - Wake holds count times 10 us, then suspends.
// - 16-bit bus write forces wake count 1400h.
package eirq_pkg;

   // Register byte offsets.
   localparam logic [11:0] OFS_EDGE_IRQ_TIMING  = 12'h340;
   localparam logic [11:0] OFS_DMA_START_PTR    = 12'h344;
   localparam logic [11:0] OFS_POWER_DOWN_CTL   = 12'h354;
   localparam logic [11:0] OFS_IRQ_MODE         = 12'h358;
   localparam logic [11:0] OFS_EVENT_STATUS     = 12'h35C;
   localparam logic [11:0] OFS_EVENT_MASK       = 12'h360;

   // Reset values.
   localparam logic [31:0] RST_EDGE_IRQ_TIMING  = 32'h0000000F;
   localparam logic [31:0] RST_DMA_START_PTR    = 32'h00000000;
   localparam logic [31:0] RST_POWER_DOWN_CTL   = 32'h03E81BA0;
   localparam logic [31:0] RST_IRQ_MODE         = 32'h00000000;

   // Field positions.
   localparam int GAP_MSB        = 31;
   localparam int GAP_LSB        = 24;
   localparam int PULSE_MSB      = 15;
   localparam int PULSE_LSB      = 0;
   localparam int WAKE_MSB       = 31;
   localparam int WAKE_LSB       = 16;
   localparam int BIT_P3_PD      = 12;
   localparam int BIT_P2_PD      = 11;
   localparam int BIT_VBAT_PWR   = 10;
   localparam int BIT_BIAS       = 5;
   localparam int BIT_VREG       = 4;
   localparam int BIT_OC3        = 3;
   localparam int BIT_OC2        = 2;
   localparam int BIT_OC1        = 1;
   localparam int BIT_HC_GATE    = 0;
   localparam int BIT_LEVEL_MODE = 0;
   localparam int BIT_BUS16_MODE = 1;
   localparam int STS_PULSE      = 0;
   localparam int STS_SUSPEND    = 1;
   localparam int STS_WIDTH      = 2;

   // Pulse and wake constants.
   localparam logic [15:0] PULSE_ZERO_LEN = 16'h0010;
   localparam logic [15:0] WAKE_BUS16_VAL = 16'h1400;

   // Timing: figures in their own unit, counts derived from the clock.
   localparam int CLK_PERIOD_NS = 10;
   localparam int MFRAME_NS     = 125000;
   localparam int WAKE_UNIT_NS  = 10000;
   localparam int MFRAME_CYC    = MFRAME_NS / CLK_PERIOD_NS;
   localparam int WAKE_UNIT_CYC = WAKE_UNIT_NS / CLK_PERIOD_NS;

   // Power and pull-down enables driven to the analogue side.
   typedef struct packed {
      logic second_port_pulldown;
      logic third_port_pulldown;
      logic battery_detector_power;
      logic bias_power_enable;
      logic regulator_suspend_enable;
      logic overcurrent1_power;
      logic overcurrent2_power;
      logic overcurrent3_power;
      logic host_clock_gate;
   } eirq_pwr_t;

endpackage : eirq_pkg

// ---- verilog/eirq_regs.sv ----
// APB register bank with edge interrupt shaping, DMA pointer and power control.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module eirq_regs #(
   parameter int MFRAME_CYCLES = eirq_pkg::MFRAME_CYC,
   parameter int WAKE_CYCLES   = eirq_pkg::WAKE_UNIT_CYC
) (
   input  wire logic             core_clk,     // 100 MHz clock.
   input  wire logic             sys_rst,      // Synchronous reset.
   input  wire logic             psel,         // APB select.
   input  wire logic             penable,      // APB access phase.
   input  wire logic             pwrite,       // APB direction.
   input  wire logic [11:0]      paddr,        // APB byte address.
   input  wire logic [31:0]      pwdata,       // APB write data.
   input  wire logic [3:0]       pstrb,        // APB byte strobes.
   output logic                  pready,       // APB ready.
   output logic [31:0]           prdata,       // APB read data.
   output logic                  pslverr,      // APB error.
   input  wire logic             irqEvent,     // Interrupt source pulse.
   input  wire logic             wakeEventPin, // Asynchronous wake request.
   output logic                  hostIrq,      // Edge or level interrupt.
   output logic                  intr,         // Masked status interrupt.
   output logic [15:0]           dmaStartAddr, // DMA start pointer.
   output logic                  suspendReq,   // Controller to suspend.
   output eirq_pkg::eirq_pwr_t   powerCtl      // Power enables.
);

   // Both dividers need a period of at least one clock; a shorter period
   // would leave the gap and wake counters without any ticks.
   initial begin
      if (MFRAME_CYCLES < 1) begin
         $error("eirq_regs: MFRAME_CYCLES must be at least one cycle");
      end
      if (WAKE_CYCLES < 1) begin
         $error("eirq_regs: WAKE_CYCLES must be at least one cycle");
      end
   end

   // Registers.
   logic [31:0] timing_q;
   logic [31:0] dmaPtr_q;
   logic [31:0] power_q;
   logic [31:0] mode_q;
   logic [eirq_pkg::STS_WIDTH-1:0] status_q;
   logic [eirq_pkg::STS_WIDTH-1:0] mask_q;

   // Pulse and gap engine.
   logic        pending_q;
   logic [15:0] pulseCnt_q;
   logic [7:0]  gapCnt_q;
   logic        mfTick;
   logic        startPulse;

   // Wake engine.
   logic        wakeMeta_q;
   logic        wakeSync_q;
   logic        wakePrev_q;
   logic        awake_q;
   logic [15:0] wakeCnt_q;
   logic        wakeTick;
   logic        wakeRise;
   logic        wakeExpire;

   // Bus decode.
   logic        access;
   logic        wrEn;
   logic        mapped;
   logic [31:0] byteMask;
   logic [31:0] rdValue;
   logic [eirq_pkg::STS_WIDTH-1:0] stsSet;

   wire logic levelMode = mode_q[eirq_pkg::BIT_LEVEL_MODE];
   wire logic bus16Mode = mode_q[eirq_pkg::BIT_BUS16_MODE];
   wire logic [7:0]  gapField =
      timing_q[eirq_pkg::GAP_MSB:eirq_pkg::GAP_LSB];
   wire logic [15:0] pulseField =
      timing_q[eirq_pkg::PULSE_MSB:eirq_pkg::PULSE_LSB];
   wire logic [15:0] wakeField =
      power_q[eirq_pkg::WAKE_MSB:eirq_pkg::WAKE_LSB];
   wire logic hcGate = power_q[eirq_pkg::BIT_HC_GATE];

   // The answer comes one cycle into the access phase, so prdata and
   // pready can both leave flip-flops.
   assign access = psel && penable && !pready;
   assign wrEn   = psel && penable && pready && pwrite;

   // Byte lanes let software update one field without touching the rest.
   always_comb begin
      byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                  {8{pstrb[1]}}, {8{pstrb[0]}}};
   end

   always_comb begin
      mapped  = 1'b1;
      rdValue = 32'h00000000;
      case (paddr)
         eirq_pkg::OFS_EDGE_IRQ_TIMING: begin
            rdValue = timing_q;
         end
         eirq_pkg::OFS_DMA_START_PTR: begin
            rdValue = 32'h00000000;
         end
         eirq_pkg::OFS_POWER_DOWN_CTL: begin
            rdValue = power_q;
         end
         eirq_pkg::OFS_IRQ_MODE: begin
            rdValue = mode_q;
         end
         eirq_pkg::OFS_EVENT_STATUS: begin
            rdValue = {30'h00000000, status_q};
         end
         eirq_pkg::OFS_EVENT_MASK: begin
            rdValue = {30'h00000000, mask_q};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= access;
         pslverr <= access && !mapped;
         prdata  <= (access && !pwrite) ? rdValue : 32'h00000000;
      end
   end

   // Reserved bits are stored as written; software keeps them at reset
   // value, so no masking is done here.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timing_q <= eirq_pkg::RST_EDGE_IRQ_TIMING;
      end else if (wrEn && paddr == eirq_pkg::OFS_EDGE_IRQ_TIMING) begin
         timing_q <= (timing_q & ~byteMask) | (pwdata & byteMask);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dmaPtr_q <= eirq_pkg::RST_DMA_START_PTR;
      end else if (wrEn && paddr == eirq_pkg::OFS_DMA_START_PTR) begin
         dmaPtr_q <= (dmaPtr_q & ~byteMask) | (pwdata & byteMask);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         power_q <= eirq_pkg::RST_POWER_DOWN_CTL;
      end else if (wrEn && paddr == eirq_pkg::OFS_POWER_DOWN_CTL) begin
         power_q <= (power_q & ~byteMask) | (pwdata & byteMask);
         // In 16-bit bus mode a write that reaches the upper half pins the
         // wake count, whatever value it carries.
         if (bus16Mode && (pstrb[3] || pstrb[2])) begin
            power_q[eirq_pkg::WAKE_MSB:eirq_pkg::WAKE_LSB] <=
               eirq_pkg::WAKE_BUS16_VAL;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mode_q <= eirq_pkg::RST_IRQ_MODE;
      end else if (wrEn && paddr == eirq_pkg::OFS_IRQ_MODE) begin
         mode_q <= (mode_q & ~byteMask) | (pwdata & byteMask);
      end
   end

   // Only byte lane 0 carries status and mask bits.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mask_q <= '0;
      end else if (wrEn && paddr == eirq_pkg::OFS_EVENT_MASK && pstrb[0]) begin
         mask_q <= pwdata[eirq_pkg::STS_WIDTH-1:0];
      end
   end

   // A new event in the clearing cycle survives: set beats clear.
   always_comb begin
      stsSet = '0;
      stsSet[eirq_pkg::STS_PULSE]   = startPulse;
      stsSet[eirq_pkg::STS_SUSPEND] = wakeExpire;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status_q <= '0;
      end else if (wrEn && paddr == eirq_pkg::OFS_EVENT_STATUS
                   && pstrb[0]) begin
         status_q <= (status_q & ~pwdata[eirq_pkg::STS_WIDTH-1:0]) | stsSet;
      end else begin
         status_q <= status_q | stsSet;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         intr <= 1'b0;
      end else begin
         intr <= |((status_q | stsSet) & mask_q);
      end
   end

   // Microframe ticks restart with every pulse so the gap is measured
   // from the pulse start, not from an arbitrary divider phase.
   eirq_tick #(
      .DIV      (MFRAME_CYCLES)
   ) u_mframe_tick (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .restart  (startPulse),
      .tick     (mfTick)
   );

   // A pulse may start when one is pending, none is running and the gap
   // has run out. Level mode bypasses the gap altogether.
   assign startPulse = !levelMode && pending_q && pulseCnt_q == 16'h0000
                       && gapCnt_q == 8'h00;

   always_ff @(posedge core_clk) begin
      if (sys_rst || levelMode) begin
         pending_q <= 1'b0;
      end else if (irqEvent) begin
         pending_q <= 1'b1;
      end else if (startPulse) begin
         pending_q <= 1'b0;
      end
   end

   // A zero pulse field stands for the fixed sixteen-clock pulse.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pulseCnt_q <= 16'h0000;
      end else if (startPulse) begin
         pulseCnt_q <= (pulseField == 16'h0000) ?
                       eirq_pkg::PULSE_ZERO_LEN : pulseField;
      end else if (pulseCnt_q != 16'h0000) begin
         pulseCnt_q <= pulseCnt_q - 16'h0001;
      end
   end

   // The gap counts whole microframe ticks; a zero field leaves it idle.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         gapCnt_q <= 8'h00;
      end else if (startPulse) begin
         gapCnt_q <= gapField;
      end else if (mfTick && gapCnt_q != 8'h00) begin
         gapCnt_q <= gapCnt_q - 8'h01;
      end
   end

   // Level mode raises the line on an event and holds it until software
   // writes 1 to status bit 0; edge mode shows the counted pulse.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hostIrq <= 1'b0;
      end else if (levelMode) begin
         hostIrq <= irqEvent || hostIrq &&
                    !(wrEn && paddr == eirq_pkg::OFS_EVENT_STATUS
                      && pstrb[0]
                      && pwdata[eirq_pkg::STS_PULSE]);
      end else begin
         hostIrq <= startPulse || pulseCnt_q > 16'h0001;
      end
   end

   // Wake requests arrive from another domain and pass two flops first.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wakeMeta_q <= 1'b0;
         wakeSync_q <= 1'b0;
         wakePrev_q <= 1'b0;
      end else begin
         wakeMeta_q <= wakeEventPin;
         wakeSync_q <= wakeMeta_q;
         wakePrev_q <= wakeSync_q;
      end
   end

   assign wakeRise = wakeSync_q && !wakePrev_q;

   eirq_tick #(
      .DIV      (WAKE_CYCLES)
   ) u_wake_tick (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .restart  (wakeRise),
      .tick     (wakeTick)
   );

   assign wakeExpire = awake_q && !hcGate && wakeTick
                       && wakeCnt_q == 16'h0001;

   // A zero count never wakes; setting the host clock gate restores
   // normal operation and cancels the timeout.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         awake_q   <= 1'b0;
         wakeCnt_q <= 16'h0000;
      end else if (hcGate) begin
         awake_q   <= 1'b0;
         wakeCnt_q <= 16'h0000;
      end else if (wakeRise && wakeField != 16'h0000) begin
         awake_q   <= 1'b1;
         wakeCnt_q <= wakeField;
      end else if (awake_q && wakeTick) begin
         wakeCnt_q <= wakeCnt_q - 16'h0001;
         awake_q   <= wakeCnt_q != 16'h0001;
      end
   end

   // The divider restarts on the wake edge, so its ticks trail by a clock.
   // Taking the expiry ahead of the awake flag wins that clock back and
   // keeps the awake window within one clock of the programmed count.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         suspendReq <= 1'b0;
      end else begin
         suspendReq <= !hcGate && !wakeRise
                       && (!awake_q || wakeExpire);
      end
   end

   always_ff @(posedge core_clk) begin
      // Outputs leave flip-flops, one clock behind the registers feeding them.
      if (sys_rst) begin
         dmaStartAddr <= 16'h0000;
         powerCtl     <= '0;
      end else begin
         dmaStartAddr <= dmaPtr_q[15:0];
         powerCtl.second_port_pulldown   <= power_q[eirq_pkg::BIT_P2_PD];
         powerCtl.third_port_pulldown    <= power_q[eirq_pkg::BIT_P3_PD];
         powerCtl.battery_detector_power <= power_q[eirq_pkg::BIT_VBAT_PWR];
         powerCtl.bias_power_enable      <= power_q[eirq_pkg::BIT_BIAS];
         powerCtl.regulator_suspend_enable <= power_q[eirq_pkg::BIT_VREG];
         powerCtl.overcurrent1_power     <= power_q[eirq_pkg::BIT_OC1];
         powerCtl.overcurrent2_power     <= power_q[eirq_pkg::BIT_OC2];
         powerCtl.overcurrent3_power     <= power_q[eirq_pkg::BIT_OC3];
         powerCtl.host_clock_gate        <= hcGate;
      end
   end

endmodule : eirq_regs

// ---- verilog/eirq_tick.sv ----
// Free-running divider that emits a one-cycle tick every DIV clocks.
`timescale 1ns/10ps
module eirq_tick #(
   parameter int DIV = 1000
) (
   input  wire logic core_clk,   // Block clock.
   input  wire logic sys_rst,    // Synchronous reset, active high.
   input  wire logic restart,    // Realigns the divider phase.
   output logic      tick        // One-cycle pulse per period.
);

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   logic [CW-1:0] cnt_q;

   initial begin
      if (DIV < 1) begin
         $error("eirq_tick: DIV must be at least one");
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || restart) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (cnt_q == CW'(DIV - 1)) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + CW'(1);
         tick  <= 1'b0;
      end
   end

endmodule : eirq_tick
